// ==== swtcm_chk.sv ====
// port assertions for the service-window timer
`timescale 1ns/10ps
`include "swtcm_consts.vh"
module swtcm_chk (
    input wire clk_in,
    input wire reset_in,
    input wire inst_cycle_in,
    input wire halt_in,
    input wire idle_in,
    input wire [`SWT_ADDR_W-1:0] addr_in,
    input wire [7:0] wr_data_in,
    input wire wr_in,
    input wire rd_in,
    input wire [7:0] rd_data_out,
    input wire fault_pin_in,
    input wire fault_pin_o_out,
    input wire fault_pin_oe_out,
    input wire pin_func_out,
    input wire fault_active_out
);
    // pulses seen while the pin is low and still being driven
    reg [5:0] held_r;
    always @(posedge clk_in) begin
        if (reset_in || !fault_pin_oe_out)
            held_r <= 6'h00;
        else if (inst_cycle_in && !fault_pin_in && held_r != 6'h3f)
            held_r <= held_r + 6'h01;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    od_low_a: assert property (fault_pin_o_out == 1'b0)
        else $error("fault pin driven high");
    rd_idle_a: assert property (!rd_in |=> rd_data_out == 8'h00)
        else $error("read data outside its slot");
    key_zero_a: assert property (rd_in && addr_in == `SWT_ADDR_SVC |=>
        rd_data_out[5:1] == 5'h00) else $error("key field readable");
    unmapped_a: assert property (rd_in && addr_in > `SWT_ADDR_STAT |=>
        rd_data_out == 8'h00) else $error("unmapped read not zero");
    pin_seen_a: assert property (rd_in && addr_in == `SWT_ADDR_STAT |=>
        rd_data_out[4] == $past(fault_pin_in)) else $error("pin status wrong");
    oe_func_a: assert property (fault_pin_oe_out |-> pin_func_out)
        else $error("pin driven while timer disabled");
    hold_min_a: assert property ($fell(fault_pin_oe_out) |->
        held_r >= 6'h10) else $error("fault released early");
    hold_max_a: assert property (held_r <= 6'h21)
        else $error("fault held too long");
endmodule
bind swtcm_top swtcm_chk i_chk (.clk_in(clk_in), .reset_in(reset_in),
    .inst_cycle_in(inst_cycle_in), .halt_in(halt_in), .idle_in(idle_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
    .rd_data_out(rd_data_out), .fault_pin_in(fault_pin_in),
    .fault_pin_o_out(fault_pin_o_out), .fault_pin_oe_out(fault_pin_oe_out),
    .pin_func_out(pin_func_out), .fault_active_out(fault_active_out));

// ==== swtcm_consts.vh ====
// constants for the service-window timer and clock monitor
`ifndef SWTCM_CONSTS_VH
`define SWTCM_CONSTS_VH

`define SWT_ADDR_W 4
`define SWT_ADDR_SVC 4'h0
`define SWT_ADDR_OPT 4'h1
`define SWT_ADDR_STAT 4'h2

`define SWT_KEY 5'h0c
`define SWT_SEL_RESET 2'h3
`define SWT_CME_RESET 1'b1
`define SWT_OPT_RESET 8'h00
`define SWT_OPT_EN_BIT 2

`define SWT_SEL_HI 7
`define SWT_SEL_LO 6
`define SWT_KEY_HI 5
`define SWT_KEY_LO 1
`define SWT_CME_BIT 0

`define SWT_LOWER_CYCLES 18'h00800
`define SWT_UPPER_BASE_CYCLES 18'h02000
`define SWT_HOLD_CYCLES 6'h10

`define SWT_CLK_MHZ 20
`define SWT_CM_GAP_US 10000
// 10 ms at 20 MHz, sized to the gap counter
`define SWT_CM_GAP_CYCLES 22'h030d40

`endif

// ==== swtcm_pin_model.sv ====
// pull-up and external reset network on the shared fault pin
`timescale 1ns/10ps
module swtcm_pin_model (
    input wire drive_in,
    input wire level_in,
    input wire stuck_low_in,
    output wire pin_out
);
    // the weak pull-up wins only while nobody sinks the line
    assign pin_out = (drive_in && !level_in) || stuck_low_in ? 1'b0 : 1'b1;
endmodule

// ==== swtcm_top.v ====
// service-window timer with clock monitor and shared open-drain fault pin
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/10ps
`include "swtcm_consts.vh"

module swtcm_top #(
    parameter [17:0] UPPER_BASE = `SWT_UPPER_BASE_CYCLES,
    parameter [17:0] LOWER = `SWT_LOWER_CYCLES,
    parameter [21:0] CM_GAP = `SWT_CM_GAP_CYCLES,
    parameter [5:0] HOLD = `SWT_HOLD_CYCLES
) (
    input wire clk_in,
    input wire reset_in,
    input wire inst_cycle_in,
    input wire halt_in,
    input wire idle_in,
    input wire [`SWT_ADDR_W-1:0] addr_in,
    input wire [7:0] wr_data_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rd_data_out,
    input wire fault_pin_in,
    output reg fault_pin_o_out,
    output reg fault_pin_oe_out,
    output reg pin_func_out,
    output reg fault_active_out
);

    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_DRIVE = 4'h2;
    localparam [3:0] ST_HOLD = 4'h4;
    localparam [3:0] ST_WAIT = 4'h8;

    reg [7:0] opt_r;
    reg [1:0] sel_r;
    reg cme_r;
    reg configured_r;
    reg [3:0] wd_state_r;
    reg [3:0] wd_state_nxt;
    reg [17:0] win_cnt_r;
    reg [5:0] hold_cnt_r;
    reg [5:0] hold_cnt_nxt;
    reg [21:0] gap_cnt_r;
    reg cm_drive_r;
    reg cm_drive_nxt;
    reg [5:0] cm_rec_r;
    reg [5:0] cm_rec_nxt;
    reg idle_d_r;
    reg fault_drive_r;
    reg [7:0] rd_nxt;

    wire wd_on;
    wire svc_wr;
    wire opt_wr;
    wire key_ok;
    wire sel_ok;
    wire suspend;
    wire idle_exit;
    wire pin_low;
    wire fault_busy;
    wire early;
    wire svc_taken;
    wire svc_ok;
    wire [17:0] limit;
    wire timeout;
    wire wd_err;
    wire restart;
    wire cm_slow;
    wire wd_drive_nxt;

    assign wd_on = ~opt_r[`SWT_OPT_EN_BIT];
    assign svc_wr = wr_in && (addr_in == `SWT_ADDR_SVC);
    assign opt_wr = wr_in && (addr_in == `SWT_ADDR_OPT);
    assign key_ok = wr_data_in[`SWT_KEY_HI:`SWT_KEY_LO] == `SWT_KEY;
    assign sel_ok = wr_data_in[`SWT_SEL_HI:`SWT_SEL_LO] == sel_r;
    assign suspend = halt_in | idle_in;
    assign idle_exit = idle_d_r & ~idle_in;
    assign pin_low = ~fault_pin_in;

    // the pin itself counts: a pin held low from power-up blocks services
    assign fault_busy = (wd_state_r != ST_IDLE) | fault_drive_r | pin_low;
    assign svc_taken = svc_wr & ~fault_busy;

    // an early service is only an error once the window is configured
    assign early = win_cnt_r < LOWER;
    assign svc_ok = configured_r ? (key_ok & sel_ok & ~early) : key_ok;

    // a narrower base shifts by the select: 8k, 16k, 32k or 64k cycles
    assign limit = UPPER_BASE << sel_r;
    // counting keeps running with the pin low, so a stuck pin times out
    assign timeout = (wd_state_r == ST_IDLE) & (win_cnt_r >= limit);
    assign wd_err = wd_on & (timeout | (svc_taken & ~svc_ok));
    assign restart = (svc_taken & svc_ok) | idle_exit;

    assign cm_slow = gap_cnt_r >= CM_GAP;
    assign wd_drive_nxt = (wd_state_nxt == ST_DRIVE) |
                          (wd_state_nxt == ST_HOLD);

    // timer fault sequence
    always @* begin
        wd_state_nxt = wd_state_r;
        hold_cnt_nxt = hold_cnt_r;
        case (wd_state_r)
            ST_IDLE: begin
                if (wd_err) begin
                    wd_state_nxt = ST_DRIVE;
                end
            end
            ST_DRIVE: begin
                hold_cnt_nxt = 6'h00;
                if (pin_low) begin
                    wd_state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (inst_cycle_in) begin
                    if (hold_cnt_r == HOLD - 6'h01) begin
                        wd_state_nxt = ST_WAIT;
                    end else begin
                        hold_cnt_nxt = hold_cnt_r + 6'h01;
                    end
                end
            end
            ST_WAIT: begin
                if (fault_pin_in) begin
                    wd_state_nxt = ST_IDLE;
                end
            end
            default: begin
                wd_state_nxt = ST_IDLE;
            end
        endcase
        if (!wd_on) begin
            wd_state_nxt = ST_IDLE;
        end
    end

    // clock monitor release after the instruction clock comes back
    always @* begin
        cm_drive_nxt = cm_drive_r;
        cm_rec_nxt = cm_rec_r;
        if (cme_r && cm_slow) begin
            cm_drive_nxt = 1'b1;
            cm_rec_nxt = 6'h00;
        end else if (!cme_r) begin
            cm_drive_nxt = 1'b0;
            cm_rec_nxt = 6'h00;
        end else if (cm_drive_r && inst_cycle_in) begin
            if (cm_rec_r == HOLD - 6'h01) begin
                cm_drive_nxt = 1'b0;
                cm_rec_nxt = 6'h00;
            end else begin
                cm_rec_nxt = cm_rec_r + 6'h01;
            end
        end
    end

    // register read data, present only in the cycle after the strobe
    always @* begin
        rd_nxt = 8'h00;
        if (rd_in) begin
            case (addr_in)
                `SWT_ADDR_SVC: begin
                    rd_nxt = {sel_r, 5'h00, cme_r};
                end
                `SWT_ADDR_OPT: begin
                    rd_nxt = opt_r;
                end
                `SWT_ADDR_STAT: begin
                    rd_nxt = {3'h0, fault_pin_in, configured_r,
                              cm_drive_r, wd_state_r != ST_IDLE,
                              fault_drive_r};
                end
                default: begin
                    rd_nxt = 8'h00;
                end
            endcase
        end
    end

    // configuration and option state
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            opt_r <= `SWT_OPT_RESET;
            sel_r <= `SWT_SEL_RESET;
            cme_r <= `SWT_CME_RESET;
            configured_r <= 1'b0;
            idle_d_r <= 1'b0;
        end else begin
            idle_d_r <= idle_in;
            if (opt_wr) begin
                opt_r <= wr_data_in;
            end
            // settings lock on the first accepted key, later writes compare
            if (svc_taken && key_ok && !configured_r) begin
                sel_r <= wr_data_in[`SWT_SEL_HI:`SWT_SEL_LO];
                cme_r <= wr_data_in[`SWT_CME_BIT];
                configured_r <= 1'b1;
            end
        end
    end

    // service window counter in instruction cycles
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            win_cnt_r <= 18'h00000;
        end else if (!wd_on || wd_state_r != ST_IDLE) begin
            win_cnt_r <= 18'h00000;
        end else if (restart) begin
            win_cnt_r <= 18'h00000;
        end else if (inst_cycle_in && !suspend && win_cnt_r < limit) begin
            win_cnt_r <= win_cnt_r + 18'h00001;
        end
    end

    // clock monitor: clk_in cycles between instruction cycle pulses
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            gap_cnt_r <= 22'h000000;
        end else if (inst_cycle_in) begin
            gap_cnt_r <= 22'h000000;
        end else if (gap_cnt_r < CM_GAP) begin
            gap_cnt_r <= gap_cnt_r + 22'h000001;
        end
    end

    // state registers
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            wd_state_r <= ST_IDLE;
            hold_cnt_r <= 6'h00;
            cm_drive_r <= 1'b0;
            cm_rec_r <= 6'h00;
        end else begin
            wd_state_r <= wd_state_nxt;
            hold_cnt_r <= hold_cnt_nxt;
            cm_drive_r <= cm_drive_nxt;
            cm_rec_r <= cm_rec_nxt;
        end
    end

    // pin drivers; the pin is only ever pulled low, high comes from pull-up
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            fault_drive_r <= 1'b0;
            fault_pin_o_out <= 1'b0;
            fault_pin_oe_out <= 1'b0;
            pin_func_out <= 1'b0;
            fault_active_out <= 1'b0;
            rd_data_out <= 8'h00;
        end else begin
            fault_drive_r <= wd_drive_nxt | cm_drive_nxt;
            fault_pin_o_out <= 1'b0;
            fault_pin_oe_out <= wd_on & (wd_drive_nxt | cm_drive_nxt);
            pin_func_out <= wd_on;
            fault_active_out <= wd_on &
                                ((wd_state_nxt != ST_IDLE) | cm_drive_nxt);
            rd_data_out <= rd_nxt;
        end
    end

endmodule

// ==== swtcm_top_tb_top.sv ====
// self-checking bench for the service-window timer
`timescale 1ns/10ps
`include "swtcm_consts.vh"
`define CHK(n, e, v) begin compares++; if ((v) !== (e)) begin err_total++; \
    $display("mismatch %s exp %h seen %h", n, e, v); end end
module swtcm_top_tb_top;
    localparam int UB = 32;
    localparam int LW = 8;
    reg clk_in = 0, reset_in = 1, inst = 0, halt = 0, idle = 0;
    reg wr = 0, rd = 0, pen = 1, low = 0, cfg = 0;
    reg [3:0] addr = 4'h0;
    reg [7:0] wd = 8'h00;
    reg [1:0] sel = 2'h3;
    reg [31:0] lf = 32'h072f;
    wire [7:0] rdat;
    wire pin, po, oe, func, act;
    int err_total = 0, compares = 0, pulses = 0, svc_at = 0;
    function automatic [31:0] lfsr(input [31:0] v);
        lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    always #25 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        inst <= pen & ~inst;
        if (inst)
            pulses++;
    end
    swtcm_top #(.UPPER_BASE(18'h00020), .LOWER(18'h00008),
        .CM_GAP(22'h000064), .HOLD(6'h10)) i_dut (.clk_in(clk_in),
        .reset_in(reset_in), .inst_cycle_in(inst), .halt_in(halt),
        .idle_in(idle), .addr_in(addr), .wr_data_in(wd), .wr_in(wr),
        .rd_in(rd), .rd_data_out(rdat), .fault_pin_in(pin),
        .fault_pin_o_out(po), .fault_pin_oe_out(oe), .pin_func_out(func),
        .fault_active_out(act));
    swtcm_pin_model i_pin (.drive_in(oe), .level_in(po),
        .stuck_low_in(low), .pin_out(pin));
    task automatic wreg(input [3:0] a, input [7:0] d);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rreg(input [3:0] a, input [7:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        @(negedge clk_in);
        `CHK("read", e, rdat)
        @(posedge clk_in);
    endtask
    task automatic waitp(input int n);
        int s;
        s = pulses;
        while (pulses < s + n)
            @(posedge clk_in);
    endtask
    task automatic fault(input string n, input int lim);
        int s;
        s = 0;
        while (oe !== 1'b1 && s < lim) begin
            @(negedge clk_in);
            s++;
        end
        `CHK(n, 1'b1, oe)
        pen <= 1'b1;
        s = pulses;
        while (oe === 1'b1 && pulses - s < 40)
            @(negedge clk_in);
        `CHK("hold", 1'b1, pulses - s >= 16 && pulses - s <= 33)
        repeat (2) @(posedge clk_in);
        `CHK("active", 1'b0, act)
        svc_at = pulses;
        $display("test %s done", n);
    endtask
    task automatic svc(input [7:0] d);
        bit bad;
        bad = d[5:1] != `SWT_KEY ||
            (cfg && (d[7:6] != sel || pulses - svc_at < LW));
        if (!bad && !cfg)
            sel = d[7:6];
        if (!bad)
            svc_at = pulses;
        cfg = cfg | !bad;
        wreg(`SWT_ADDR_SVC, d);
        if (bad)
            fault("service error", 8);
        else begin
            repeat (3) @(posedge clk_in);
            `CHK("no fault", 1'b0, oe)
        end
    endtask
    task automatic conclude;
        $display("counts %0d compares %0d mismatches", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        @(negedge clk_in);
        `CHK("func", 1'b1, func)
        @(posedge clk_in);
        rreg(`SWT_ADDR_SVC, 8'hc1);
        rreg(4'h9, 8'h00);
        low <= 1'b1;
        repeat (3) @(posedge clk_in);
        wreg(`SWT_ADDR_SVC, 8'h00);
        low <= 1'b0;
        repeat (4) @(posedge clk_in);
        `CHK("ignored", 1'b0, oe)
        svc(8'h00);
        svc(8'h19);
        rreg(`SWT_ADDR_SVC, 8'h01);
        for (int i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            waitp(LW + 2 + lf % 18);
            svc({2'b00, `SWT_KEY, lf[8]});
        end
        rreg(`SWT_ADDR_SVC, 8'h01);
        waitp(LW + 2);
        svc(8'hd9);
        waitp(2);
        svc(8'h19);
        waitp(UB - 4);
        `CHK("early", 1'b0, oe)
        fault("timeout", 16);
        waitp(LW + 2);
        svc(8'h19);
        halt <= 1'b1;
        waitp(2 * UB);
        `CHK("halt", 1'b0, oe)
        halt <= 1'b0;
        waitp(LW + 2);
        svc(8'h19);
        waitp(20);
        idle <= 1'b1;
        waitp(8);
        idle <= 1'b0;
        waitp(20);
        `CHK("idle exit", 1'b0, oe)
        svc(8'h19);
        pen <= 1'b0;
        fault("clock monitor", 130);
        wreg(`SWT_ADDR_OPT, 8'h04);
        rreg(`SWT_ADDR_OPT, 8'h04);
        `CHK("func off", 1'b0, func)
        waitp(2 * UB);
        `CHK("disabled", 1'b0, oe)
        conclude();
    end
    initial begin
        #(50 * 20000);
        err_total++;
        conclude();
    end
endmodule
